/* rtl/serial_adc_control_sequencer.sv */
`timescale 1ns/1ps
module serial_adc_control_sequencer (
  // System side, conversion clock
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Link pins
  input  wire logic                     io_clk,
  input  wire logic                     cs_n,
  input  wire logic                     addr_in,
  output logic                          data_out,
  output logic                          data_out_oe,
  // Strap: link clock and conversion clock are one wire
  input  wire logic                     common_clock_mode,
  // Analog core
  input  wire logic                     comp_high,
  output logic [adc_seq_pkg::RESULT_BITS-1:0] dac_code,
  output adc_seq_pkg::analog_ctrl_t     analog_ctrl,
  // Status
  output logic                          conv_busy
);

  // ****************************************
  // Select recognition, conversion clock domain
  // ****************************************
  logic cs_n_settled;
  logic sel_active;
  logic next_sel_active;
  logic sel_fall;

  // Three flops then agreement keeps noise on select out of the sequence
  pin_sync #(.WIDTH(1), .RST(1'b1)) u_cs_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (cs_n),
    .q      (cs_n_settled)
  );

  always_comb begin
    next_sel_active = ~cs_n_settled;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_active <= 1'b0;
    end else begin
      sel_active <= next_sel_active;
    end
  end

  assign sel_fall = next_sel_active & ~sel_active;

  // Link counters and address shift are held reset while select is not recognised
  logic link_rst_n;
  assign link_rst_n = resetn & sel_active;

  // ****************************************
  // Link domain: counters on falls
  // ****************************************
  logic                               mode_link;
  logic [1:0]                         skip_cnt;
  logic [3:0]                         fall_cnt;
  logic [1:0]                         next_skip_cnt;
  logic [3:0]                         next_fall_cnt;
  logic [1:0]                         skip_goal;
  logic                               skip_done;

  pin_sync #(.WIDTH(1), .RST(1'b0)) u_mode_sync (
    .clk    (io_clk),
    .resetn (resetn),
    .d      (common_clock_mode),
    .q      (mode_link)
  );

  assign skip_goal = mode_link ? adc_seq_pkg::COMMON_SKIP : adc_seq_pkg::NO_SKIP;
  assign skip_done = (skip_cnt == skip_goal);

  always_comb begin
    next_skip_cnt = skip_cnt;
    next_fall_cnt = fall_cnt;
    if (!skip_done) begin
      next_skip_cnt = skip_cnt + 2'h1;
    end else if (fall_cnt == adc_seq_pkg::SEQ_CLOCKS - 4'h1) begin
      next_fall_cnt = 4'h0;
    end else begin
      next_fall_cnt = fall_cnt + 4'h1;
    end
  end

  always_ff @(negedge io_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      skip_cnt <= 2'h0;
      fall_cnt <= 4'h0;
    end else begin
      skip_cnt <= next_skip_cnt;
      fall_cnt <= next_fall_cnt;
    end
  end

  // ****************************************
  // Link domain: address shift on rises
  // ****************************************
  logic [adc_seq_pkg::ADDR_BITS-1:0] addr_sh;
  logic [adc_seq_pkg::ADDR_BITS-1:0] next_addr_sh;

  always_comb begin
    next_addr_sh = addr_sh;
    if (skip_done && (fall_cnt < adc_seq_pkg::ADDR_CLOCKS)) begin
      next_addr_sh = {addr_sh[adc_seq_pkg::ADDR_BITS-2:0], addr_in};
    end
  end

  always_ff @(posedge io_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      addr_sh <= adc_seq_pkg::CH_RESET;
    end else begin
      addr_sh <= next_addr_sh;
    end
  end

  // ****************************************
  // Link domain: event toggles and channel word
  // ****************************************
  // Toggles survive deselect so that a reset never looks like an event
  logic                              samp_tgl;
  logic                              hold_tgl;
  logic [adc_seq_pkg::ADDR_BITS-1:0] chan_word;
  logic                              next_samp_tgl;
  logic                              next_hold_tgl;
  logic [adc_seq_pkg::ADDR_BITS-1:0] next_chan_word;
  logic                              fall_valid;

  assign fall_valid = link_rst_n & skip_done;

  always_comb begin
    next_samp_tgl  = samp_tgl;
    next_hold_tgl  = hold_tgl;
    next_chan_word = chan_word;
    if (fall_valid && (fall_cnt == adc_seq_pkg::ADDR_CLOCKS - 4'h1)) begin
      next_samp_tgl  = ~samp_tgl;
      next_chan_word = addr_sh;
    end
    if (fall_valid && (fall_cnt == adc_seq_pkg::SEQ_CLOCKS - 4'h1)) begin
      next_hold_tgl = ~hold_tgl;
    end
  end

  always_ff @(negedge io_clk or negedge resetn) begin
    if (!resetn) begin
      samp_tgl  <= 1'b0;
      hold_tgl  <= 1'b0;
      chan_word <= adc_seq_pkg::CH_RESET;
    end else begin
      samp_tgl  <= next_samp_tgl;
      hold_tgl  <= next_hold_tgl;
      chan_word <= next_chan_word;
    end
  end

  // ****************************************
  // Events into the conversion clock domain
  // ****************************************
  logic [1:0] tgl_sync;
  logic       samp_seen;
  logic       hold_seen;
  logic       samp_evt;
  logic       hold_evt;

  // Each event toggle crosses on its own; the channel word is stable by then
  pin_sync #(.WIDTH(2), .RST(1'b0)) u_evt_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({hold_tgl, samp_tgl}),
    .q      (tgl_sync)
  );

  assign samp_evt = tgl_sync[0] ^ samp_seen;
  assign hold_evt = tgl_sync[1] ^ hold_seen;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_seen <= 1'b0;
      hold_seen <= 1'b0;
    end else begin
      samp_seen <= tgl_sync[0];
      hold_seen <= tgl_sync[1];
    end
  end

  // ****************************************
  // Sample, hold and conversion control
  // ****************************************
  adc_seq_pkg::conv_state_t          state;
  adc_seq_pkg::conv_state_t          next_state;
  logic [adc_seq_pkg::ADDR_BITS-1:0] channel;
  logic [adc_seq_pkg::ADDR_BITS-1:0] next_channel;
  logic [adc_seq_pkg::RESULT_BITS-1:0] result;
  logic [adc_seq_pkg::RESULT_BITS-1:0] next_result;
  logic                              sar_start;
  logic                              sar_abort;
  logic                              sar_busy;
  logic                              sar_done;

  always_comb begin
    next_state   = state;
    next_channel = channel;
    next_result  = result;
    sar_start    = 1'b0;
    sar_abort    = 1'b0;
    case (state)
      adc_seq_pkg::ST_IDLE: begin
        if (samp_evt) begin
          next_state   = adc_seq_pkg::ST_SAMPLE;
          next_channel = chan_word;
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (hold_evt) begin
          next_state = adc_seq_pkg::ST_CONVERT;
          sar_start  = 1'b1;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (samp_evt) begin
          // Previous result stays; the new access restarts here
          next_state   = adc_seq_pkg::ST_SAMPLE;
          next_channel = chan_word;
          sar_abort    = 1'b1;
        end else if (sar_done) begin
          next_state  = adc_seq_pkg::ST_IDLE;
          next_result = dac_code;
        end
      end
      default: begin
        next_state = adc_seq_pkg::ST_IDLE;
      end
    endcase
    if (sel_fall && (state != adc_seq_pkg::ST_IDLE)) begin
      next_state = adc_seq_pkg::ST_IDLE;
      sar_start  = 1'b0;
      sar_abort  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= adc_seq_pkg::ST_IDLE;
      channel <= adc_seq_pkg::CH_RESET;
      result  <= adc_seq_pkg::RESULT_RESET;
    end else begin
      state   <= next_state;
      channel <= next_channel;
      result  <= next_result;
    end
  end

  // Conversion runs on clk, which in common-clock mode is the shared wire
  sar_engine #(
    .CYCLES (adc_seq_pkg::CONV_CYCLES),
    .STEP   (adc_seq_pkg::BIT_CYCLES)
  ) u_sar (
    .clk       (clk),
    .resetn    (resetn),
    .start     (sar_start),
    .abort     (sar_abort),
    .comp_high (comp_high),
    .trial     (dac_code),
    .busy      (sar_busy),
    .done      (sar_done)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign analog_ctrl.channel   = channel;
  assign analog_ctrl.self_test = (channel == adc_seq_pkg::SELF_TEST_CH);
  assign analog_ctrl.sample    = (state == adc_seq_pkg::ST_SAMPLE);
  assign analog_ctrl.hold      = (state == adc_seq_pkg::ST_CONVERT);
  assign conv_busy             = sar_busy;

  // The result word only changes at conversion end, well away from a read
  always_comb begin
    data_out    = 1'b0;
    data_out_oe = sel_active;
    if (sel_active && (fall_cnt < adc_seq_pkg::SEQ_CLOCKS)) begin
      data_out = result[3'h7 - fall_cnt[2:0]];
    end
  end

endmodule : serial_adc_control_sequencer

/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_BITS   = 5;
  localparam int RESULT_BITS = 8;
  localparam int SYNC_STAGES = 3;

  // ****************************************
  // Sequence positions on the link clock
  // ****************************************
  localparam logic [3:0] ADDR_CLOCKS  = 4'h5;
  localparam logic [3:0] SEQ_CLOCKS   = 4'h8;
  localparam logic [1:0] COMMON_SKIP  = 2'h2;
  localparam logic [1:0] NO_SKIP      = 2'h0;

  // ****************************************
  // Conversion timing in conversion-clock cycles
  // ****************************************
  localparam int CONV_CYCLES = 36;
  localparam int BIT_CYCLES  = 4;

  // ****************************************
  // Channel codes and reset values
  // ****************************************
  localparam logic [ADDR_BITS-1:0]   SELF_TEST_CH = 5'h13;
  localparam logic [ADDR_BITS-1:0]   CH_RESET     = 5'h00;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_BITS-1:0] channel;
    logic                 self_test;
    logic                 sample;
    logic                 hold;
  } analog_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage : adc_seq_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int   WIDTH = 1,
  parameter logic RST   = 1'b0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Raw level and its settled copy
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_q;

  // ****************************************
  // Agreement filter: first stage is read only by the second
  // ****************************************
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= {WIDTH{RST}};
      s2 <= {WIDTH{RST}};
      s3 <= {WIDTH{RST}};
      q  <= {WIDTH{RST}};
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

endmodule : pin_sync

/* rtl/sar_engine.sv */
`timescale 1ns/1ps
module sar_engine #(
  parameter int CYCLES = adc_seq_pkg::CONV_CYCLES,
  parameter int STEP   = adc_seq_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                resetn,
  // Control
  input  wire logic                                start,
  input  wire logic                                abort,
  // Analog core
  input  wire logic                                comp_high,
  output logic      [adc_seq_pkg::RESULT_BITS-1:0] trial,
  // Status
  output logic                                     busy,
  output logic                                     done
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] STEP_M1 = CW'(STEP - 1);

  logic [CW-1:0]                       cnt;
  logic [2:0]                          bit_idx;
  logic [CW-1:0]                       next_cnt;
  logic [2:0]                          next_bit_idx;
  logic [adc_seq_pkg::RESULT_BITS-1:0] next_trial;
  logic                                next_busy;
  logic                                next_done;

  // ****************************************
  // One decision per step, MSB first; the tail of the window is settling
  // ****************************************
  always_comb begin
    next_cnt     = cnt;
    next_bit_idx = bit_idx;
    next_trial   = trial;
    next_busy    = busy;
    next_done    = 1'b0;
    if (start) begin
      next_cnt     = '0;
      next_bit_idx = 3'h7;
      next_trial   = 8'h80;
      next_busy    = 1'b1;
    end else if (abort) begin
      next_busy = 1'b0;
    end else if (busy) begin
      next_cnt = cnt + 1'b1;
      if ((cnt[1:0] == STEP_M1[1:0]) && (cnt < CW'(STEP * 8))) begin
        next_trial[bit_idx] = comp_high;
        if (bit_idx != 3'h0) begin
          next_trial[bit_idx - 3'h1] = 1'b1;
          next_bit_idx = bit_idx - 3'h1;
        end
      end
      if (cnt == LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt     <= '0;
      bit_idx <= 3'h7;
      trial   <= adc_seq_pkg::RESULT_RESET;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      bit_idx <= next_bit_idx;
      trial   <= next_trial;
      busy    <= next_busy;
      done    <= next_done;
    end
  end

endmodule : sar_engine

/* dv/adc_seq_chk.sv */
`timescale 1ns/1ps
module adc_seq_chk (
  // Clock and reset
  input wire logic                                clk,
  input wire logic                                resetn,
  // Link pins
  input wire logic                                cs_n,
  input wire logic                                data_out_oe,
  // Analog core and status
  input wire logic [adc_seq_pkg::RESULT_BITS-1:0] dac_code,
  input wire adc_seq_pkg::analog_ctrl_t           analog_ctrl,
  input wire logic                                conv_busy
);
  // ********************
  // Busy length counter
  // ********************
  logic [5:0] busy_cnt;
  logic [5:0] next_busy_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  always_comb next_busy_cnt = conv_busy ? busy_cnt + 6'h01 : 6'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busy_cnt <= 6'h00;
    else busy_cnt <= next_busy_cnt;
  end

  chk_oe_deselect: assert property (cs_n [*7] |-> !data_out_oe)
    else $error("output enabled while deselected");
  chk_select_filter: assert property ($fell(cs_n) && !data_out_oe |->
    ##1 !data_out_oe ##1 !data_out_oe ##[1:4] data_out_oe)
    else $error("select recognised too early or too late");
  chk_busy_bound: assert property (conv_busy |-> busy_cnt < 6'h24)
    else $error("conversion longer than 36 cycles");
  chk_hold_busy: assert property ($rose(analog_ctrl.hold) |-> ##[0:1] conv_busy)
    else $error("hold without conversion");
  chk_dac_start: assert property ($rose(conv_busy) |-> ##[0:1] dac_code == 8'h80)
    else $error("first trial code wrong");
  chk_self_test: assert property (analog_ctrl.self_test ==
    (analog_ctrl.channel == adc_seq_pkg::SELF_TEST_CH))
    else $error("self test decode wrong");
  chk_sample_active: assert property ($rose(analog_ctrl.sample) |-> data_out_oe)
    else $error("sampling while deselected");
  chk_hold_follows: assert property ($rose(analog_ctrl.hold) |->
    $past(analog_ctrl.sample))
    else $error("hold without prior sampling");

  // Aborted conversions show as a short busy period
  cover property ($rose(conv_busy));
  cover property ($rose(analog_ctrl.self_test));
  cover property ($fell(conv_busy) && busy_cnt < 6'h24);
endmodule : adc_seq_chk

bind serial_adc_control_sequencer adc_seq_chk u_chk (
  .clk, .resetn, .cs_n, .data_out_oe, .dac_code, .analog_ctrl, .conv_busy);

/* dv/link_host_model.sv */
`timescale 1ns/1ps
module link_host_model (
  // Link pins
  output logic      io_clk,
  output logic      addr_in,
  input  wire logic data_out,
  // Bench view
  output logic      in_stretch
);
  // ********************
  // Controller side of one access
  // ********************
  initial begin
    io_clk = 1'b0;
    addr_in = 1'b0;
    in_stretch = 1'b0;
  end

  // Link clock stands low between accesses; its phase is free against clk
  task automatic access(input logic [4:0] addr, input int stretch_ns,
                        output logic [7:0] got);
    for (int k = 0; k < 8; k++) begin
      if (k < 5) addr_in = addr[4-k];
      #62.5 io_clk = 1'b1;
      got[7-k] = data_out;
      if (k == 7) begin
        in_stretch = 1'b1;
        #(stretch_ns);
        in_stretch = 1'b0;
      end
      #62.5 io_clk = 1'b0;
    end
    // Released line does not keep the last bit
    addr_in = ~addr_in;
  endtask : access

  // Bare clocks with no address, for the strap synchroniser and the shared-clock skip
  task automatic pulse(input int n);
    repeat (n) begin
      #62.5 io_clk = 1'b1;
      #62.5 io_clk = 1'b0;
    end
  endtask : pulse
endmodule : link_host_model

/* dv/test_serial_adc_control_sequencer.sv */
`timescale 1ns/1ps
module test_serial_adc_control_sequencer;
  // ********************
  // Signals
  // ********************
  logic                                clk;
  logic                                resetn;
  logic                                cs_n;
  logic                                io_clk;
  logic                                addr_in;
  logic                                data_out;
  logic                                data_out_oe;
  logic                                comp_high;
  logic [adc_seq_pkg::RESULT_BITS-1:0] dac_code;
  adc_seq_pkg::analog_ctrl_t           analog_ctrl;
  logic                                conv_busy;
  logic                                in_stretch;
  logic                                common_clock_mode;
  logic [7:0]                          vin;
  logic [7:0]                          got;
  int                                  mismatches;
  int                                  comparisons;
  int                                  cycles;

  serial_adc_control_sequencer u_dut (
    .clk, .resetn, .io_clk, .cs_n, .addr_in, .data_out, .data_out_oe,
    .common_clock_mode, .comp_high, .dac_code, .analog_ctrl, .conv_busy);
  link_host_model u_host (.io_clk, .addr_in, .data_out, .in_stretch);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ideal comparator; its one cycle of lag falls inside bit settling
  always @(posedge clk) comp_high <= (vin >= dac_code);

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ********************
  // Helpers
  // ********************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic select(input logic lvl);
    @(posedge clk) cs_n <= lvl;
    repeat (8) tick();
    cmp("oe", {7'h00, ~lvl}, {7'h00, data_out_oe});
  endtask : select

  task automatic convert(output int len);
    int n;
    n = 0;
    len = 0;
    while (conv_busy !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    while (conv_busy === 1'b1 && len < 100) begin
      tick();
      len++;
    end
  endtask : convert

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ********************
  // Scenarios
  // ********************
  task automatic s_deselected();
    u_host.access(5'h1F, 0, got);
    repeat (4) tick();
    cmp("oe", 8'h00, {7'h00, data_out_oe});
    cmp("sample", 8'h00, {7'h00, analog_ctrl.sample});
    cmp("channel", 8'h00, {3'h0, analog_ctrl.channel});
  endtask : s_deselected

  task automatic s_first();
    int len;
    select(1'b0);
    u_host.access(adc_seq_pkg::SELF_TEST_CH, 0, got);
    cmp("result", adc_seq_pkg::RESULT_RESET, got);
    cmp("self test", 8'h01, {7'h00, analog_ctrl.self_test});
    convert(len);
    cmp("busy", 8'h24, len[7:0]);
    select(1'b1);
  endtask : s_first

  task automatic s_strobe();
    int len;
    vin = 8'h3C;
    select(1'b0);
    cmp("msb", 8'h01, {7'h00, data_out});
    fork
      u_host.access(5'h0A, 1000, got);
      begin
        wait (in_stretch === 1'b1);
        repeat (50) tick();
        cmp("sample", 8'h01, {7'h00, analog_ctrl.sample});
        cmp("hold", 8'h00, {7'h00, analog_ctrl.hold});
      end
    join
    cmp("result", 8'hA5, got);
    cmp("channel", 8'h0A, {3'h0, analog_ctrl.channel});
    convert(len);
    cmp("busy", 8'h24, len[7:0]);
  endtask : s_strobe

  // Select dropped again mid-conversion throws that conversion away
  task automatic s_abort();
    int len;
    vin = 8'h77;
    u_host.access(5'h01, 0, got);
    cmp("result", 8'h3C, got);
    repeat (12) tick();
    select(1'b1);
    select(1'b0);
    cmp("busy", 8'h00, {7'h00, conv_busy});
    u_host.access(5'h02, 0, got);
    cmp("result", 8'h3C, got);
    convert(len);
    cmp("busy", 8'h24, len[7:0]);
    u_host.access(5'h02, 0, got);
    cmp("result", 8'h77, got);
    select(1'b1);
  endtask : s_abort

  // Shared-clock strap: four bare clocks before select recognise it, two after select are the skip
  task automatic s_common();
    @(posedge clk) common_clock_mode <= 1'b1;
    u_host.pulse(4);
    select(1'b0);
    u_host.pulse(2);
    u_host.access(adc_seq_pkg::SELF_TEST_CH, 0, got);
    cmp("result", 8'h77, got);
    cmp("channel", 8'h13, {3'h0, analog_ctrl.channel});
    select(1'b1);
  endtask : s_common

  initial begin
    resetn = 1'b0;
    cs_n = 1'b1;
    vin = 8'hA5;
    common_clock_mode = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) tick();
    s_deselected();
    s_first();
    s_strobe();
    s_abort();
    s_common();
    stop_test();
  end
endmodule : test_serial_adc_control_sequencer
